// file: core/ead_pkg.sv
// ead_pkg: constants shared by the error action dispatcher files.
// assumes a 32-bit apb register bus and one core clock domain.
package ead_pkg;
   // register byte offsets
   localparam logic [7:0] EAD_CTRL_OFF = 8'h00;
   localparam logic [7:0] EAD_STAT_OFF = 8'h04;
   localparam logic [7:0] EAD_IRQ_OFF = 8'h08;
   localparam logic [7:0] EAD_MASK_OFF = 8'h0C;
   localparam logic [7:0] EAD_FSR_OFF = 8'h10;
   // control register fields
   localparam int EAD_CTL_UHA = 0;
   localparam int EAD_CTL_WEAK = 1;
   localparam int EAD_CTL_UTE = 2;
   localparam int EAD_CTL_CTE = 3;
   localparam int EAD_CTL_IE = 4;
   localparam int EAD_CTL_SUSP = 5;
   localparam int EAD_CTL_W = 6;
   localparam logic [5:0] EAD_CTL_RST = 6'h00;
   // fault status fields (write one to clear)
   localparam int EAD_FSR_UE = 0;
   localparam int EAD_FSR_CE = 1;
   localparam int EAD_FSR_DG = 2;
   localparam int EAD_FSR_W = 3;
   // action encoding, index equals priority order
   typedef enum logic [3:0] {
      EAD_ACT_NONE,
      EAD_ACT_FATAL,
      EAD_ACT_ERRST,
      EAD_ACT_ADE_SINGLE,
      EAD_ACT_ADE_MULTI,
      EAD_ACT_DAE,
      EAD_ACT_IAE,
      EAD_ACT_RESTRAIN
   } ead_act_t;
   // interrupt status bits
   localparam int EAD_IRQ_FATAL = 0;
   localparam int EAD_IRQ_ERRST = 1;
   localparam int EAD_IRQ_TRAP = 2;
   localparam int EAD_IRQ_W = 3;
endpackage : ead_pkg

// file: core/ead_prio.sv
// ead_prio: fixed priority picker over the pending error conditions.
// assumes pending flags are stable in the cycle they are sampled.
`timescale 1ns/1ps
module ead_prio
   import ead_pkg::*;
(
   // pending conditions
   input wire logic fatal_p,
   input wire logic errst_p,
   input wire logic ade_p,
   input wire logic ade_multi,
   input wire logic dae_p,
   input wire logic iae_p,
   input wire logic restrain_p,
   // chosen action
   output ead_act_t act
);
   // highest priority wins, lower ones stay pending
   always_comb begin
      if (fatal_p) act = EAD_ACT_FATAL;
      else if (errst_p) act = EAD_ACT_ERRST;
      else if (ade_p) act = ade_multi ? EAD_ACT_ADE_MULTI : EAD_ACT_ADE_SINGLE;
      else if (dae_p) act = EAD_ACT_DAE;
      else if (iae_p) act = EAD_ACT_IAE;
      else if (restrain_p) act = EAD_ACT_RESTRAIN;
      else act = EAD_ACT_NONE;
   end
endmodule : ead_prio

// file: core/ead_dispatch.sv
// ead_dispatch: classifies detected errors and dispatches one action.
// assumes detector pulses and trap acks are on pclk; apb slave inside.
//
// Overview of operation
// - sync urgent, handler idle: single async trap
// - sync urgent, handler active: multiple async trap
// - autonomous urgent, trap enabled: single async trap
// - autonomous urgent, trap disabled: keep it pending
// - instruction fault: own trap, else multiple async
// - data fault: own trap, else multiple async
// - fatal, error, async, data, instruction, restrainable
// - restrainable trap may survive fault status clear
// - uncorrectable-set trap survives correctable clear
// - correctable-set trap survives uncorrectable clear
// - restrainable trap suppressed by listed conditions
// - pending autonomous urgent traps once enabled
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module ead_dispatch
   import ead_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // error detectors, one-cycle pulses
   input wire logic fatal_class,
   input wire logic state_transition_class,
   input wire logic instruction_sync_urgent_error,
   input wire logic autonomous_urgent_error,
   input wire logic instruction_access_fault,
   input wire logic data_access_fault,
   input wire logic uncorrectable_error,
   input wire logic correctable_error,
   input wire logic degradation_error,
   // thread trap logic
   input wire logic trap_ack,
   output logic trap_req,
   output ead_act_t trap_kind,
   // system controller
   output logic fatal_state,
   output logic fatal_to_system,
   output logic system_por,
   output logic error_state,
   output logic watchdog_reset,
   // interrupt
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   logic [EAD_CTL_W-1:0] error_control_reg;
   logic [EAD_FSR_W-1:0] async_fault_status;
   logic [EAD_IRQ_W-1:0] irq_stat;
   logic [EAD_IRQ_W-1:0] irq_mask;
   logic fatal_p, errst_p, ade_p, ade_multi, dae_p, iae_p;
   logic restrain_p, aug_hold;
   logic urgent_handler_active, weak_detection, interrupt_enable;
   logic uncorrectable_trap_enable, correctable_degrade_trap_enable;
   logic suspended, aug_trap_on, rest_allowed, rest_new;
   logic take;
   ead_act_t act;
   logic wr;
   // strobes decoded once from the apb phase and the address
   logic rd_setup, ctrl_wr, mask_wr, fsr_wr, irq_rd;
   // trap handshake, gated restrainable request and event vectors
   logic trap_taken, restrain_live;
   logic [EAD_FSR_W-1:0] fsr_set, fsr_clr;
   logic [EAD_IRQ_W-1:0] irq_set;

   ////////////////////////////////////////////////////////////////////
   // address compare shared by the write, error and read-clear decodes
   function automatic logic reg_hit(logic [7:0] addr, logic [7:0] off);
      reg_hit = (addr == off);
   endfunction : reg_hit

   // five word offsets answer; every other address is refused
   function automatic logic reg_mapped(logic [7:0] addr);
      reg_mapped = reg_hit(addr, EAD_CTRL_OFF) ||
                   reg_hit(addr, EAD_STAT_OFF) ||
                   reg_hit(addr, EAD_IRQ_OFF) ||
                   reg_hit(addr, EAD_MASK_OFF) ||
                   reg_hit(addr, EAD_FSR_OFF);
   endfunction : reg_mapped

   // a pending trap retires only when its own kind was handed over;
   // act may already show a newer, higher action at that edge
   function automatic logic kind_taken(logic taken, ead_act_t kind,
                                       ead_act_t want_a,
                                       ead_act_t want_b);
      kind_taken = taken && (kind == want_a || kind == want_b);
   endfunction : kind_taken

   assign urgent_handler_active = error_control_reg[EAD_CTL_UHA];
   assign weak_detection = error_control_reg[EAD_CTL_WEAK];
   assign uncorrectable_trap_enable = error_control_reg[EAD_CTL_UTE];
   assign correctable_degrade_trap_enable = error_control_reg[EAD_CTL_CTE];
   assign interrupt_enable = error_control_reg[EAD_CTL_IE];
   assign suspended = error_control_reg[EAD_CTL_SUSP];

   // zero wait-state apb; access phase completes at once
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   // refused address: error in the access phase, the write is dropped
   always_comb begin
      if (reg_mapped(paddr)) pslverr = 1'b0;
      else pslverr = psel && penable;
   end

   // read data is captured in the setup cycle, so the read-to-clear
   // side effect happens there as well and no event slips between
   assign rd_setup = psel && !penable && !pwrite;
   assign ctrl_wr = wr && reg_hit(paddr, EAD_CTRL_OFF);
   assign mask_wr = wr && reg_hit(paddr, EAD_MASK_OFF);
   assign fsr_wr = wr && reg_hit(paddr, EAD_FSR_OFF);
   assign irq_rd = rd_setup && reg_hit(paddr, EAD_IRQ_OFF);

   ////////////////////////////////////////////////////////////////////
   // trap enables derived from control bits
   assign aug_trap_on = !urgent_handler_active && !weak_detection
                        && !suspended;
   assign rest_allowed = !urgent_handler_active && !weak_detection
                         && interrupt_enable && !suspended;
   // a restrainable detection with its trap enable set is always recorded;
   // suppression only holds back its delivery, so nothing is lost while masked
   assign rest_new =
      (uncorrectable_error && uncorrectable_trap_enable) ||
      ((correctable_error || degradation_error)
       && correctable_degrade_trap_enable);
   assign restrain_live = restrain_p && rest_allowed;

   // priority pick; the chosen one is handed to the trap logic
   ead_prio u_prio (
      .fatal_p(fatal_p),
      .errst_p(errst_p),
      .ade_p(ade_p),
      .ade_multi(ade_multi),
      .dae_p(dae_p),
      .iae_p(iae_p),
      .restrain_p(restrain_live),
      .act(act)
   );
   // handshake seen by the trap logic
   assign trap_taken = trap_req && trap_ack;
   // fatal and error state are taken without a handshake
   assign take = (act == EAD_ACT_FATAL) || (act == EAD_ACT_ERRST) ||
                 trap_taken;

   ////////////////////////////////////////////////////////////////////
   // trap request presented from flops to keep kind stable; once up it
   // stays, even if a higher action arrives, so the trap logic never
   // sees the kind change under a raised request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_req <= 1'b0;
         trap_kind <= EAD_ACT_NONE;
      end else if (trap_req && !trap_ack) begin
         trap_req <= 1'b1; // hold until taken
      end else if (!take && act != EAD_ACT_NONE && act != EAD_ACT_FATAL
                   && act != EAD_ACT_ERRST) begin
         trap_req <= 1'b1;
         trap_kind <= act;
      end else begin
         trap_req <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fatal class: sticky until reset; the picker then shows fatal
   // forever, which blocks every lower trap until the system reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fatal_p <= 1'b0;
         fatal_state <= 1'b0;
         fatal_to_system <= 1'b0;
         system_por <= 1'b0;
      end else begin
         if (fatal_class) fatal_p <= 1'b1;
         if (act == EAD_ACT_FATAL) begin
            fatal_state <= 1'b1;
            fatal_to_system <= 1'b1;
         end
         system_por <= fatal_state; // reset follows the report
      end
   end

   // error state transition, watchdog reset held once entered
   // a new detection in the clearing edge wins and is taken again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         errst_p <= 1'b0;
         error_state <= 1'b0;
         watchdog_reset <= 1'b0;
      end else begin
         if (state_transition_class) errst_p <= 1'b1;
         else if (act == EAD_ACT_ERRST) errst_p <= 1'b0;
         if (act == EAD_ACT_ERRST) begin
            error_state <= 1'b1;
            watchdog_reset <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // urgent class: async data trap, multiple if handler busy; an
   // autonomous error seen while its trap is off waits in aug_hold
   // and is released once the trap is on and no async trap pends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ade_p <= 1'b0;
         ade_multi <= 1'b0;
         aug_hold <= 1'b0;
      end else begin
         if (autonomous_urgent_error && !aug_trap_on)
            aug_hold <= 1'b1;
         else if (aug_hold && aug_trap_on && !ade_p)
            aug_hold <= 1'b0;
         if (instruction_sync_urgent_error
             || (instruction_access_fault && urgent_handler_active)
             || (data_access_fault && urgent_handler_active)) begin
            ade_p <= 1'b1;
            ade_multi <= ade_multi | urgent_handler_active;
         end else if ((autonomous_urgent_error && aug_trap_on)
                      || (aug_hold && aug_trap_on && !ade_p)) begin
            ade_p <= 1'b1;
         end else if (kind_taken(trap_taken, trap_kind,
                                 EAD_ACT_ADE_SINGLE,
                                 EAD_ACT_ADE_MULTI)) begin
            ade_p <= 1'b0;
            ade_multi <= 1'b0;
         end
      end
   end

   // precise access faults when no urgent handler is running
   // with the handler running they fold into the multiple trap above
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dae_p <= 1'b0;
         iae_p <= 1'b0;
      end else begin
         if (data_access_fault && !urgent_handler_active)
            dae_p <= 1'b1;
         else if (kind_taken(trap_taken, trap_kind, EAD_ACT_DAE,
                             EAD_ACT_DAE))
            dae_p <= 1'b0;
         if (instruction_access_fault && !urgent_handler_active)
            iae_p <= 1'b1;
         else if (kind_taken(trap_taken, trap_kind, EAD_ACT_IAE,
                             EAD_ACT_IAE))
            iae_p <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // restrainable trap pending is independent of fault status clears;
   // while suppressed it waits here and the picker never sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         restrain_p <= 1'b0;
      end else if (rest_new) begin
         restrain_p <= 1'b1;
      end else if (kind_taken(trap_taken, trap_kind, EAD_ACT_RESTRAIN,
                              EAD_ACT_RESTRAIN)) begin
         restrain_p <= 1'b0;
      end
   end

   // fault events and software clears of the status log
   always_comb begin
      fsr_set = '0;
      fsr_set[EAD_FSR_UE] = uncorrectable_error;
      fsr_set[EAD_FSR_CE] = correctable_error;
      fsr_set[EAD_FSR_DG] = degradation_error;
   end
   assign fsr_clr = fsr_wr ? pwdata[EAD_FSR_W-1:0] : '0;

   // fault status log, write one to clear, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async_fault_status <= '0;
      end else begin
         async_fault_status <= (async_fault_status & ~fsr_clr) | fsr_set;
      end
   end

   // control and mask registers; a change of control bits acts on the
   // next edge, both on new detections and on what is pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_control_reg <= EAD_CTL_RST;
         irq_mask <= '0;
      end else begin
         if (ctrl_wr) error_control_reg <= pwdata[EAD_CTL_W-1:0];
         if (mask_wr) irq_mask <= pwdata[EAD_IRQ_W-1:0];
      end
   end

   // interrupt events: fatal, error state, and one bit for any trap taken
   always_comb begin
      irq_set = '0;
      irq_set[EAD_IRQ_FATAL] = (act == EAD_ACT_FATAL);
      irq_set[EAD_IRQ_ERRST] = (act == EAD_ACT_ERRST);
      irq_set[EAD_IRQ_TRAP] = trap_taken;
   end

   // interrupt status, cleared by the read that captures it; an event
   // in that same edge wins the clear and shows on the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_rd ? '0 : irq_stat) | irq_set;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // read data captured in the setup cycle and held through the
   // access phase, which lets pready stay tied high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_setup) begin
         case (paddr)
            EAD_CTRL_OFF: prdata <= 32'(error_control_reg);
            EAD_STAT_OFF: prdata <= 32'({restrain_p, iae_p, dae_p,
               ade_multi, ade_p, aug_hold, errst_p, fatal_p,
               watchdog_reset, error_state, fatal_state});
            EAD_IRQ_OFF: prdata <= 32'(irq_stat);
            EAD_MASK_OFF: prdata <= 32'(irq_mask);
            EAD_FSR_OFF: prdata <= 32'(async_fault_status);
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule : ead_dispatch

// file: bench/ead_monitor.sv
// ead_monitor: port-level checks of the error action dispatcher.
// assumes one pclk domain and the ead_pkg action encoding.
`timescale 1ns/1ps
module ead_monitor
   import ead_pkg::*;
(
   // clock, reset and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // detectors and trap handshake
   input wire logic fatal_class,
   input wire logic state_transition_class,
   input wire logic trap_req,
   input wire logic trap_ack,
   input ead_act_t trap_kind,
   // system controller
   input wire logic fatal_state,
   input wire logic fatal_to_system,
   input wire logic system_por,
   input wire logic error_state,
   input wire logic watchdog_reset
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////
   property p_fatal; fatal_class |-> ##[1:3] fatal_state && fatal_to_system;
   endproperty
   a_fatal: assert property (p_fatal) else $error("fatal late");
   property p_por; $rose(fatal_state) |-> ##[0:2] system_por; endproperty
   a_por: assert property (p_por) else $error("por missing");
   property p_errst;
      state_transition_class |-> ##[1:3] error_state && watchdog_reset;
   endproperty
   a_errst: assert property (p_errst) else $error("errst late");
   property p_wdog; error_state |-> watchdog_reset; endproperty
   a_wdog: assert property (p_wdog) else $error("wdog low");
   // a pending trap waits unchanged for its acknowledge
   property p_hold;
      trap_req && !trap_ack |=> trap_req && $stable(trap_kind);
   endproperty
   a_hold: assert property (p_hold) else $error("trap dropped");
   property p_fell; $fell(trap_req) |-> $past(trap_ack); endproperty
   a_fell: assert property (p_fell) else $error("unacked drop");
   property p_kind;
      trap_req |-> trap_kind inside {[EAD_ACT_ADE_SINGLE:EAD_ACT_RESTRAIN]};
   endproperty
   a_kind: assert property (p_kind) else $error("bad kind");
   property p_rdy; psel && penable |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no pready");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
endmodule : ead_monitor
bind ead_dispatch ead_monitor ead_monitor_i (.pclk, .presetn, .psel,
   .penable, .pready, .pslverr, .fatal_class, .state_transition_class,
   .trap_req, .trap_ack, .trap_kind, .fatal_state, .fatal_to_system,
   .system_por, .error_state, .watchdog_reset);

// file: bench/ead_trap_model.sv
// ead_trap_model: thread trap logic that takes dispatched traps.
// assumes trap_req holds until the ack edge; hold stalls acceptance.
`timescale 1ns/1ps
module ead_trap_model
   import ead_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold,
   input wire logic trap_req,
   input ead_act_t trap_kind,
   output logic trap_ack,
   output logic got,
   output ead_act_t got_kind
);
   // one-cycle ack; a stalled model leaves lower traps waiting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_ack <= 1'b0;
         got <= 1'b0;
         got_kind <= EAD_ACT_NONE;
      end else begin
         trap_ack <= trap_req && !trap_ack && !hold;
         got <= trap_req && trap_ack;
         if (trap_req && trap_ack) got_kind <= trap_kind;
      end
   end
endmodule : ead_trap_model

// file: bench/test_ead_dispatch.sv
// test_ead_dispatch: apb and detector driven checks of the dispatcher.
// assumes zero-wait apb and the trap model as thread trap logic.
`timescale 1ns/1ps
module test_ead_dispatch;
   import ead_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic hold = 0, pready, pslverr, trap_req, trap_ack, got, irq;
   logic fst, fsys, spor, est, wdog;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [8:0] det = 9'h000;
   ead_act_t trap_kind, got_kind;
   int err_total = 0, cmp_count = 0, n;
   logic [31:0] tc[8] = '{0, 1, 0, 0, 1, 0, 1, 32'h14};
   int ts[8] = '{2, 2, 3, 4, 4, 5, 5, 6};
   ead_act_t te[8] = '{EAD_ACT_ADE_SINGLE, EAD_ACT_ADE_MULTI,
      EAD_ACT_ADE_SINGLE, EAD_ACT_IAE, EAD_ACT_ADE_MULTI, EAD_ACT_DAE,
      EAD_ACT_ADE_MULTI, EAD_ACT_RESTRAIN};
   always #2.5 pclk = ~pclk;
   ead_dispatch ead_dispatch_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .fatal_class(det[0]),
      .state_transition_class(det[1]),
      .instruction_sync_urgent_error(det[2]),
      .autonomous_urgent_error(det[3]), .instruction_access_fault(det[4]),
      .data_access_fault(det[5]), .uncorrectable_error(det[6]),
      .correctable_error(det[7]), .degradation_error(det[8]), .trap_ack,
      .trap_req, .trap_kind, .fatal_state(fst), .fatal_to_system(fsys),
      .system_por(spor), .error_state(est), .watchdog_reset(wdog), .irq);
   ead_trap_model ead_trap_model_i (.pclk, .presetn, .hold, .trap_req,
      .trap_kind, .trap_ack, .got, .got_kind);
   ////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", s, exp, seen);
      end
   endtask : chk
   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int i;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin err_total++; finish_test(); end
      rd = prdata;
      n = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic pulse(logic [8:0] v);
      @(posedge pclk); det <= v;
      @(posedge pclk); det <= 9'h000;
   endtask : pulse
   task automatic trap(ead_act_t e);
      int i;
      for (i = 0; i < 40; i++) begin
         @(negedge pclk);
         if (got === 1'b1) break;
      end
      if (i == 40) begin err_total++; finish_test(); end
      chk("trap_kind", got_kind, e);
   endtask : trap
   task automatic none;
      n = 0;
      repeat (12) begin @(negedge pclk); n += (got !== 1'b0); end
      chk("no trap", n, 0);
   endtask : none
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      apb(0, EAD_CTRL_OFF, 0); chk("ctrl rst", rd, 0);
      apb(0, EAD_STAT_OFF, 0); chk("stat rst", rd, 0);
      apb(0, 8'h40, 0); chk("unmapped err", n, 1); chk("unmapped", rd, 0);
      for (int k = 0; k < 8; k++) begin
         apb(1, EAD_CTRL_OFF, tc[k]);
         pulse(9'h001 << ts[k]);
         trap(te[k]);
      end
      // masked autonomous urgent and suppressed restrainable stay pending, then trap
      apb(1, EAD_CTRL_OFF, 1); pulse(9'h008); none();
      apb(1, EAD_CTRL_OFF, 0); trap(EAD_ACT_ADE_SINGLE);
      apb(1, EAD_CTRL_OFF, 32'h15); pulse(9'h040); none();
      apb(1, EAD_CTRL_OFF, 32'h14); trap(EAD_ACT_RESTRAIN);
      // clearing fault status leaves a set restrainable trap
      hold <= 1; pulse(9'h040); pulse(9'h080);
      apb(1, EAD_FSR_OFF, 32'h6); apb(1, EAD_FSR_OFF, 32'h7);
      hold <= 0; trap(EAD_ACT_RESTRAIN);
      apb(0, EAD_FSR_OFF, 0); chk("fsr empty", rd, 0);
      apb(1, EAD_CTRL_OFF, 32'h18); hold <= 1; pulse(9'h1C0);
      apb(1, EAD_FSR_OFF, 32'h1); apb(0, EAD_FSR_OFF, 0);
      chk("fsr kept", rd, 32'h6);
      hold <= 0; trap(EAD_ACT_RESTRAIN);
      // simultaneous faults leave in priority order
      apb(1, EAD_CTRL_OFF, 0); apb(1, EAD_MASK_OFF, 0);
      apb(0, EAD_IRQ_OFF, 0);
      hold <= 1; pulse(9'h034); hold <= 0;
      trap(EAD_ACT_ADE_SINGLE);
      trap(EAD_ACT_DAE);
      trap(EAD_ACT_IAE);
      chk("irq masked", irq, 0);
      apb(1, EAD_MASK_OFF, 32'h4); @(negedge pclk); chk("irq", irq, 1);
      apb(0, EAD_IRQ_OFF, 0); chk("irq stat", rd, 32'h4);
      apb(0, EAD_IRQ_OFF, 0); chk("irq clr", rd, 0);
      @(negedge pclk); chk("irq off", irq, 0);
      pulse(9'h002); repeat (3) @(negedge pclk);
      chk("errst", {est, wdog, fst}, 3'b110);
      pulse(9'h001); repeat (4) @(negedge pclk);
      chk("fatal", {fst, fsys, spor}, 3'b111);
      finish_test();
   end
endmodule : test_ead_dispatch
